// ---- common/ssl_pkg.sv ----
// Constants shared by the twelve-channel serial shift and latch LED sink block.
package ssl_pkg;

  // **********************************************
  // Widths and depths
  // **********************************************
  localparam int SSL_CHANNELS = 12;
  localparam int SSL_FIFO_DEPTH = 8;
  localparam int SSL_PIN_COUNT = 5;

  // **********************************************
  // Positions of the pins in the synchroniser vector
  // **********************************************
  localparam int SSL_PIN_SHIFT_CLK = 0;
  localparam int SSL_PIN_LATCH_CLK = 1;
  localparam int SSL_PIN_SERIAL_IN = 2;
  localparam int SSL_PIN_CLEAR_N = 3;
  localparam int SSL_PIN_OUT_EN_N = 4;

  // **********************************************
  // Reset values
  // **********************************************
  localparam logic [11:0] SSL_WORD_RST = 12'h000;
  localparam logic [4:0] SSL_PINS_RST = 5'h18;
  localparam logic SSL_CASCADE_RST = 1'b0;
  localparam logic SSL_SINK_LEVEL = 1'b0;

endpackage : ssl_pkg

// ---- design/ssl_led_sink.sv ----
// Serial-in shift register, latch word FIFO, storage register and open-drain LED sink outputs.

// **********************************************
// Word FIFO between the latch edge and the storage register
// **********************************************
module ssl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_flush,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != DEPTH[PW:0]);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    count <= DEPTH[PW:0]) else $error("FIFO count above depth");

endmodule : ssl_fifo

// **********************************************
// Top level
// **********************************************
module ssl_led_sink
  import ssl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial link pins from the host
  input wire logic i_shift_clk,
  input wire logic i_latch_clk,
  input wire logic i_serial_in,
  input wire logic i_clear_n,
  input wire logic i_output_enable_n,
  // Cascade to the next device
  output logic o_serial_cascade_out,
  // Open-drain sink pins, one bit per channel
  output logic [SSL_CHANNELS-1:0] o_sink_out,
  output logic [SSL_CHANNELS-1:0] o_sink_oe,
  // Back-pressure towards the latch edge
  output logic o_latch_ready
);

  // **********************************************
  // Pin synchronisers
  // **********************************************
  // All pins are asynchronous to i_clk, so every one passes two flops before use.
  logic [SSL_PIN_COUNT-1:0] pin_meta;
  logic [SSL_PIN_COUNT-1:0] pin_sync;
  logic shift_clk_prev;
  logic latch_clk_prev;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta <= SSL_PINS_RST;
      pin_sync <= SSL_PINS_RST;
    end else begin
      pin_meta <= {i_output_enable_n, i_clear_n, i_serial_in, i_latch_clk, i_shift_clk};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_clk_prev <= 1'b0;
      latch_clk_prev <= 1'b0;
    end else begin
      shift_clk_prev <= pin_sync[SSL_PIN_SHIFT_CLK];
      latch_clk_prev <= pin_sync[SSL_PIN_LATCH_CLK];
    end
  end

  logic shift_rise;
  logic shift_fall;
  logic latch_rise;
  logic clear_ok;
  logic out_en_n;
  logic serial_bit;

  assign shift_rise = pin_sync[SSL_PIN_SHIFT_CLK] && !shift_clk_prev;
  assign shift_fall = !pin_sync[SSL_PIN_SHIFT_CLK] && shift_clk_prev;
  assign latch_rise = pin_sync[SSL_PIN_LATCH_CLK] && !latch_clk_prev;
  assign clear_ok = pin_sync[SSL_PIN_CLEAR_N];
  assign out_en_n = pin_sync[SSL_PIN_OUT_EN_N];
  assign serial_bit = pin_sync[SSL_PIN_SERIAL_IN];

  // **********************************************
  // Shift register and cascade output
  // **********************************************
  logic [SSL_CHANNELS-1:0] shift_reg;
  logic [SSL_CHANNELS-1:0] next_shift_reg;

  // The first bit in walks up to the top stage after twelve edges.
  assign next_shift_reg = {shift_reg[SSL_CHANNELS-2:0], serial_bit};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_reg <= SSL_WORD_RST;
    end else if (!clear_ok) begin
      shift_reg <= SSL_WORD_RST;
    end else if (shift_rise) begin
      shift_reg <= next_shift_reg;
    end
  end

  // Moving on the falling edge gives the next device a full half period of setup.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_cascade_out <= SSL_CASCADE_RST;
    end else if (!clear_ok) begin
      o_serial_cascade_out <= SSL_CASCADE_RST;
    end else if (shift_fall) begin
      o_serial_cascade_out <= shift_reg[SSL_CHANNELS-1];
    end
  end

  // **********************************************
  // Latch capture and word FIFO
  // **********************************************
  // The word is snapshot at the latch edge, so later shifting cannot corrupt it while it waits.
  logic latch_pending;
  logic [SSL_CHANNELS-1:0] latch_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [SSL_CHANNELS-1:0] fifo_out_data;
  logic push;
  logic pop;

  assign push = latch_pending && fifo_in_ready;
  assign pop = fifo_out_valid && clear_ok;
  assign o_latch_ready = fifo_in_ready && !latch_pending;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_pending <= 1'b0;
      latch_word <= SSL_WORD_RST;
    end else if (!clear_ok) begin
      latch_pending <= 1'b0;
      latch_word <= SSL_WORD_RST;
    end else if (latch_rise) begin
      latch_pending <= 1'b1;
      latch_word <= shift_reg;
    end else if (push) begin
      latch_pending <= 1'b0;
    end
  end

  ssl_fifo #(
    .WIDTH(SSL_CHANNELS),
    .DEPTH(SSL_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_flush(!clear_ok),
    .i_in_valid(latch_pending),
    .o_in_ready(fifo_in_ready),
    .i_in_data(latch_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(clear_ok),
    .o_out_data(fifo_out_data)
  );

  // **********************************************
  // Storage register and sink outputs
  // **********************************************
  logic [SSL_CHANNELS-1:0] storage;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      storage <= SSL_WORD_RST;
    end else if (!clear_ok) begin
      storage <= SSL_WORD_RST;
    end else if (pop) begin
      storage <= fifo_out_data;
    end
  end

  // A set storage bit pulls its pin low; the pin is never driven high.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sink_oe <= SSL_WORD_RST;
      o_sink_out <= SSL_WORD_RST;
    end else begin
      o_sink_out <= {SSL_CHANNELS{SSL_SINK_LEVEL}};
      if (out_en_n || !clear_ok) begin
        o_sink_oe <= SSL_WORD_RST;
      end else begin
        o_sink_oe <= storage;
      end
    end
  end

  // **********************************************
  // Assertions
  // **********************************************
  sequence latch_start_s;
    latch_rise && clear_ok && !latch_pending && !fifo_out_valid;
  endsequence

  sequence latch_travel_s;
    latch_start_s ##1 clear_ok [*2];
  endsequence

  shift_step_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    shift_rise && clear_ok |=> shift_reg == {$past(shift_reg[SSL_CHANNELS-2:0]), $past(serial_bit)})
    else $error("Shift register did not take the serial bit");

  shift_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !shift_rise && clear_ok |=> $stable(shift_reg))
    else $error("Shift register moved without a shift edge");

  latch_copy_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    latch_travel_s |=> storage == $past(shift_reg, 3))
    else $error("Storage did not receive the latched word");

  storage_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !pop && clear_ok |=> $stable(storage))
    else $error("Storage changed without a latch word");

  clear_all_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !clear_ok |=> shift_reg == '0 && storage == '0 && !o_serial_cascade_out && !fifo_out_valid)
    else $error("Clear left a register set");

  clear_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !clear_ok |=> o_sink_oe == '0)
    else $error("Sinks on while clear is low");

  sink_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    out_en_n |=> o_sink_oe == '0 && o_sink_out == '0)
    else $error("Sinks on while outputs disabled");

  sink_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !out_en_n && clear_ok |=> o_sink_oe == $past(storage))
    else $error("Sinks do not follow storage");

  cascade_fall_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    shift_fall && clear_ok |=> o_serial_cascade_out == $past(shift_reg[SSL_CHANNELS-1]))
    else $error("Cascade out missed the last stage");

  cascade_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !shift_fall && clear_ok |=> $stable(o_serial_cascade_out))
    else $error("Cascade out changed off a falling edge");

endmodule : ssl_led_sink

// ---- tb/ssl_host_model.sv ----
// Host model that shifts words into the sink block and pulses the latch clock.
module ssl_host_model (
  // Timing reference
  input wire logic i_clk,
  // Link pins
  output logic o_shift_clk,
  output logic o_latch_clk,
  output logic o_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half of a 320 ns link period at the 40 ns system clock.
  localparam int HALF = 4;

  initial begin
    o_shift_clk = 1'b0;
    o_latch_clk = 1'b0;
    o_serial_in = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(negedge i_clk);
  endtask : wait_half

  // The top bit goes first so that it lands on channel eleven.
  task automatic send_word(input logic [11:0] w);
    // Data moves with the falling shift edge, so each bit has a full half period on both sides of the rise.
    for (int i = 11; i >= 0; i--) begin
      o_serial_in = w[i];
      wait_half();
      o_shift_clk = 1'b1;
      wait_half();
      o_shift_clk = 1'b0;
    end
    // The line is flipped after the frame so a stale bit never passes for data.
    o_serial_in = ~o_serial_in;
  endtask : send_word

  task automatic pulse_latch();
    wait_half();
    o_latch_clk = 1'b1;
    wait_half();
    o_latch_clk = 1'b0;
  endtask : pulse_latch
endmodule : ssl_host_model

// ---- tb/ssl_led_sink_tb.sv ----
// Self-checking bench for the twelve-channel serial shift and latch LED sink.
module ssl_led_sink_tb
  import ssl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic reset_n;
  logic clear_n;
  logic oe_n;
  logic shift_clk;
  logic latch_clk;
  logic serial_in;
  logic cascade;
  logic latch_ready;
  logic [SSL_CHANNELS-1:0] sink_out;
  logic [SSL_CHANNELS-1:0] sink_oe;
  int err_total = 0;
  int checked = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ssl_led_sink dut (
    .i_clk(clk),
    .i_reset_n(reset_n),
    .i_shift_clk(shift_clk),
    .i_latch_clk(latch_clk),
    .i_serial_in(serial_in),
    .i_clear_n(clear_n),
    .i_output_enable_n(oe_n),
    .o_serial_cascade_out(cascade),
    .o_sink_out(sink_out),
    .o_sink_oe(sink_oe),
    .o_latch_ready(latch_ready)
  );

  ssl_host_model host (
    .i_clk(clk),
    .o_shift_clk(shift_clk),
    .o_latch_clk(latch_clk),
    .o_serial_in(serial_in)
  );

  // **********************************************
  // Checks
  // **********************************************
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cycles

  // **********************************************
  // Scenarios
  // **********************************************
  task automatic t_load();
    host.send_word(12'hA5C);
    wait_cycles(8);
    chk_word(sink_oe, 12'h000, "before latch");
    chk_bit(cascade, 1'b1, "cascade first");
    host.pulse_latch();
    wait_cycles(8);
    chk_word(sink_oe, 12'hA5C, "first word");
    chk_word(sink_out, 12'h000, "sink data");
    chk_bit(latch_ready, 1'b1, "latch ready after drain");
    $display("test load done");
  endtask : t_load

  task automatic t_indep();
    host.send_word(12'h3C1);
    wait_cycles(8);
    chk_word(sink_oe, 12'hA5C, "held word");
    chk_bit(cascade, 1'b0, "cascade last stage");
    host.pulse_latch();
    wait_cycles(8);
    chk_word(sink_oe, 12'h3C1, "second word");
    $display("test independent clocks done");
  endtask : t_indep

  task automatic t_oe();
    oe_n = 1'b1;
    wait_cycles(6);
    chk_word(sink_oe, 12'h000, "disabled");
    chk_word(sink_out, 12'h000, "disabled data");
    oe_n = 1'b0;
    wait_cycles(6);
    chk_word(sink_oe, 12'h3C1, "enabled again");
    $display("test output enable done");
  endtask : t_oe

  task automatic t_clear();
    // A set top stage first, so that the cascade check below can see the clear act.
    host.send_word(12'h801);
    wait_cycles(8);
    chk_bit(cascade, 1'b1, "cascade before clear");
    clear_n = 1'b0;
    wait_cycles(6);
    chk_word(sink_oe, 12'h000, "clear low");
    chk_bit(cascade, 1'b0, "cascade cleared");
    host.pulse_latch();
    wait_cycles(6);
    clear_n = 1'b1;
    wait_cycles(8);
    chk_word(sink_oe, 12'h000, "storage cleared");
    // A latch with no new shifting exposes whatever the shift register kept.
    host.pulse_latch();
    wait_cycles(8);
    chk_word(sink_oe, 12'h000, "shift cleared");
    $display("test clear done");
  endtask : t_clear

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    reset_n = 1'b0;
    clear_n = 1'b1;
    oe_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    wait_cycles(4);
    t_load();
    t_indep();
    t_oe();
    t_clear();
    close_out();
  end

  // Three words and four latches need about 16.4 us, so this leaves wide margin.
  initial begin
    #200us;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule : ssl_led_sink_tb
